// ==== rtl/pdhdr_pkg.sv ====
// Function
// (R01) Extended flag is zero for control and data messages, one for extended ones.
// (R02) With extended clear, object count gives 32-bit objects; zero means control.
// (R03) Unchunked extended message: object count field is reserved, no length meaning.
// (R04) Full chunk carries count 7; short chunk padded, count includes extended header.
// (R05) Keep 3-bit message ID counter, cleared at power-on, Soft Reset and Hard Reset.
// (R06) Advance message ID only after the partner returns GoodCRC.
// (R07) Power role bit reports present role: one Source, zero Sink, SOP only.
// (R08) Source-only messages carry Source role; Sink-only messages carry Sink role.
// (R09) In role swaps, initial Source marks PS_RDY Sink; initial Sink later marks Source.
// (R10) GoodCRC answering the swap PS_RDY still carries the Sink role.
// (R11) Received power role bit is never checked and never triggers recovery.
// (R12) Revision codes 00b 1.0, 01b 2.0, 10b 3.0; 11b never transmitted.
// (R13) All transmitted messages carry one consistent revision value; code uses one for SOP and another for SOP'/SOP''.
// (R14) Operation is possible at every revision from 2.0 upward.
// (R15) Learn partner revision from Source_Capabilities or Request; keep agreed until detach.
// (R16) Cable plug talk uses 2.0 before contract, lowest common revision after.
// (R17) Cable plug follows port revision but reports its own highest revision.
// (R18) Cable plug uses one revision for SOP' and SOP''; both plugs match.
// (R19) Data role bit: one DFP, zero UFP; zero in every non-SOP packet.
// (R20) Received non-GoodCRC with our own data role starts connector error recovery.
// (R21) After Hard Reset, attachment restores default data role from pull-down or pull-up.
// (R22) Port without USB data defaults to DFP as Source, UFP as Sink.
// (R23) In SOP' and SOP'' the power role bit flags cable plug origin instead.
// (R24) Message type sits in bits four to zero, decoded with count and extended flag.
// (R25) Header fields pack into one 16-bit word and unpack combinationally.
package pdhdr_pkg;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] PDHDR_CTRL_OFS = 8'h00;
  localparam logic [7:0] PDHDR_REV_OFS = 8'h04;
  localparam logic [7:0] PDHDR_STAT_OFS = 8'h08;
  localparam logic [7:0] PDHDR_MSGID_OFS = 8'h0C;
  localparam int CTL_PROLE = 0;
  localparam int CTL_DROLE = 1;
  localparam int CTL_USBCOMM = 2;
  localparam int CTL_PULLUP = 3;
  localparam int CTL_CONTRACT = 4;
  localparam int CTL_SWAP = 5;
  localparam int CTL_ATTACH = 8;
  localparam int CTL_DETACH = 9;
  localparam int CTL_SOFTRST = 10;
  localparam int CTL_HARDRST = 11;

  // ****************************************
  // Header codes and reset values
  // ****************************************
  localparam logic [1:0] REV_10 = 2'h0;
  localparam logic [1:0] REV_20 = 2'h1;
  localparam logic [1:0] REV_30 = 2'h2;
  localparam logic [1:0] REV_RSVD = 2'h3;
  localparam logic [1:0] LOCAL_REV_RST = REV_30;
  localparam logic [1:0] PLUG_REV_RST = REV_20;
  localparam logic [1:0] SOP_P = 2'h0;
  localparam logic [1:0] SOP_PRIME = 2'h1;
  localparam logic [1:0] SOP_DPRIME = 2'h2;
  localparam logic [4:0] TYPE_GOODCRC = 5'h01;
  localparam logic [4:0] TYPE_GOTOMIN = 5'h02;
  localparam logic [2:0] CHUNK_FULL_NDO = 3'h7;
  localparam logic [5:0] EXT_HDR_BYTES = 6'h02;
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_EXT = 2'h2;

  // Field order matches the wire layout, so a cast packs or unpacks the header.
  typedef struct packed {
    logic ext;
    logic [2:0] ndo;
    logic [2:0] id;
    logic prole;
    logic [1:0] rev;
    logic drole;
    logic [4:0] mtype;
  } pdhdr_fields_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_ARMED = 3'b010,
    SW_GCRC = 3'b100
  } pdhdr_swap_t;

endpackage : pdhdr_pkg

// ==== rtl/pdhdr_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module pdhdr_top
  import pdhdr_pkg::*;
#(
  parameter logic [4:0] PING_TYPE = 5'h05,
  parameter logic [4:0] PSRDY_TYPE = 5'h06,
  parameter logic [4:0] SRCCAP_TYPE = 5'h01,
  parameter logic [4:0] REQUEST_TYPE = 5'h02
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transmit request from the protocol layer.
  input wire logic tx_req_i,
  input wire logic [1:0] tx_sop_i,
  input wire logic [4:0] tx_type_i,
  input wire logic [2:0] tx_ndo_i,
  input wire logic tx_ext_i,
  input wire logic tx_chunked_i,
  input wire logic [4:0] tx_chunk_bytes_i,
  input wire logic tx_from_pe_i,
  output logic tx_valid_o,
  output logic [15:0] tx_hdr_o,
  // Partner acknowledge of our last message.
  input wire logic goodcrc_rx_i,
  input wire logic [1:0] goodcrc_sop_i,
  // Received header.
  input wire logic rx_valid_i,
  input wire logic [1:0] rx_sop_i,
  input wire logic [15:0] rx_hdr_i,
  output logic rx_valid_o,
  output var pdhdr_fields_t rx_fields_o,
  output logic [1:0] rx_kind_o,
  output logic rx_ndo_valid_o,
  output logic err_recovery_o
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Lower of two revision codes.
  function automatic logic [1:0] rev_min(input logic [1:0] a, input logic [1:0] b);
    rev_min = (a < b) ? a : b;
  endfunction : rev_min

  // Keep a revision inside the range we can run: 2.0 up to 3.0, never the reserved code.
  function automatic logic [1:0] rev_legal(input logic [1:0] r);
    if (r == REV_RSVD) begin
      rev_legal = REV_30;
    end else if (r < REV_20) begin
      rev_legal = REV_20;
    end else begin
      rev_legal = r;
    end
  endfunction : rev_legal

  // ****************************************
  // State
  // ****************************************
  logic ack_ff;
  logic prole_ff;
  logic drole_ff;
  logic usbcomm_ff;
  logic pullup_ff;
  logic contract_ff;
  logic [1:0] local_rev_ff;
  logic [1:0] plug_rev_ff;
  logic [1:0] partner_rev_ff;
  logic partner_known_ff;
  logic [2:0] msgid_ff [3];
  logic [2:0] last_rx_id_ff [3];
  pdhdr_swap_t swap_ff;
  pdhdr_swap_t nxt_swap;
  logic nxt_prole;
  logic tx_valid_ff;
  logic [15:0] tx_hdr_ff;
  logic rx_valid_ff;
  pdhdr_fields_t rx_fields_ff;
  logic [1:0] rx_kind_ff;
  logic rx_ndo_valid_ff;
  logic err_ff;
  logic [31:0] rd_data_ff;

  // ****************************************
  // Bus decode
  // ****************************************

  // One access per request; ack drops the cycle after it was given.
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == PDHDR_CTRL_OFS);
  wire hit_rev = (wb_adr_i == PDHDR_REV_OFS);
  wire wr_ctrl0 = bus_wr && hit_ctrl && wb_sel_i[0];
  wire wr_ctrl1 = bus_wr && hit_ctrl && wb_sel_i[1];
  wire wr_rev0 = bus_wr && hit_rev && wb_sel_i[0];
  wire attach_p = wr_ctrl1 && wb_dat_i[CTL_ATTACH];
  wire detach_p = wr_ctrl1 && wb_dat_i[CTL_DETACH];
  wire soft_rst_p = wr_ctrl1 && wb_dat_i[CTL_SOFTRST];
  wire hard_rst_p = wr_ctrl1 && wb_dat_i[CTL_HARDRST];
  wire swap_arm_p = wr_ctrl0 && wb_dat_i[CTL_SWAP];
  wire id_clear = soft_rst_p || hard_rst_p;

  // ****************************************
  // Revision selection
  // ****************************************

  // (R15) agreed revision
  wire [1:0] agreed_rev = partner_known_ff ? rev_min(local_rev_ff, partner_rev_ff) : local_rev_ff;
  // (R16) cable plug revision
  wire [1:0] plug_op_rev = contract_ff ? rev_min(agreed_rev, plug_rev_ff) : REV_20;
  // (R13) one revision per path
  wire [1:0] port_op_rev = contract_ff ? agreed_rev : local_rev_ff;

  // Read mux; unmapped offsets read zero and still get an ack.
  wire [31:0] rd_ctrl = {27'h0, contract_ff, pullup_ff, usbcomm_ff, drole_ff, prole_ff};
  wire [31:0] rd_rev = {28'h0, plug_rev_ff, local_rev_ff};
  wire [31:0] rd_stat = {20'h0, swap_ff, drole_ff, prole_ff, partner_known_ff, plug_op_rev,
                         agreed_rev, partner_rev_ff};
  wire [31:0] rd_msgid = {21'h0, msgid_ff[2], 1'b0, msgid_ff[1], 1'b0, msgid_ff[0]};
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = rd_ctrl;
    end else if (hit_rev) begin
      rd_mux = rd_rev;
    end else if (wb_adr_i == PDHDR_STAT_OFS) begin
      rd_mux = rd_stat;
    end else if (wb_adr_i == PDHDR_MSGID_OFS) begin
      rd_mux = rd_msgid;
    end else begin
      rd_mux = 32'h0;
    end
  end

  // Registered answer: ack and data come one edge after the request is seen.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_ff <= 1'b0;
      rd_data_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req;
      rd_data_ff <= bus_req ? rd_mux : 32'h0;
    end
  end

  // ****************************************
  // Transmit header assembly
  // ****************************************
  wire tx_sop = (tx_sop_i == SOP_P);
  wire tx_ctrl = !tx_ext_i && (tx_ndo_i == 3'h0);
  wire tx_data = !tx_ext_i && (tx_ndo_i != 3'h0);
  wire tx_gcrc = tx_ctrl && (tx_type_i == TYPE_GOODCRC);
  wire tx_psrdy = tx_ctrl && (tx_type_i == PSRDY_TYPE);
  wire [1:0] tx_sop_idx = (tx_sop_i == SOP_DPRIME) ? SOP_DPRIME : tx_sop_i;
  wire [5:0] chunk_sum = {1'b0, tx_chunk_bytes_i} + EXT_HDR_BYTES + 6'h03;
  wire [3:0] chunk_objs = chunk_sum[5:2];

  // (R04) chunk object count, capped at a full chunk
  wire [2:0] chunk_ndo = (chunk_objs > {1'b0, CHUNK_FULL_NDO}) ? CHUNK_FULL_NDO : chunk_objs[2:0];
  // (R03) unchunked extended leaves the count at zero
  wire [2:0] tx_ndo_f = tx_ext_i ? (tx_chunked_i ? chunk_ndo : 3'h0) : tx_ndo_i;

  // (R08) fixed roles for role-exclusive messages
  wire src_only = tx_ctrl && ((tx_type_i == TYPE_GOTOMIN) || (tx_type_i == PING_TYPE));
  wire snk_only = tx_data && (tx_type_i == REQUEST_TYPE);
  // (R09) initial Source marks its PS_RDY as Sink
  wire swap_src_psrdy = (swap_ff == SW_ARMED) && prole_ff && tx_psrdy && tx_from_pe_i;
  // (R10) protocol-layer GoodCRC after the flip still says Sink
  wire swap_gcrc = (swap_ff == SW_GCRC) && tx_gcrc && !tx_from_pe_i;
  logic tx_prole_bit;
  always_comb begin
    if (!tx_sop) begin
      // (R23) we are a port, never a cable plug
      tx_prole_bit = 1'b0;
    end else if (src_only) begin
      tx_prole_bit = 1'b1;
    end else if (snk_only || swap_src_psrdy || swap_gcrc) begin
      tx_prole_bit = 1'b0;
    end else begin
      // (R07) present power role
      tx_prole_bit = prole_ff;
    end
  end

  pdhdr_fields_t tx_f;
  always_comb begin
    // (R01) extended flag straight from the message class
    tx_f.ext = tx_ext_i;
    // (R02) object count
    tx_f.ndo = tx_ndo_f;
    // (R05) current counter, or the echoed ID for GoodCRC
    tx_f.id = tx_gcrc ? last_rx_id_ff[tx_sop_idx] : msgid_ff[tx_sop_idx];
    tx_f.prole = tx_prole_bit;
    // (R12) only legal codes reach the wire
    tx_f.rev = rev_legal(tx_sop ? port_op_rev : plug_op_rev);
    // (R19) data role only in SOP
    tx_f.drole = tx_sop ? drole_ff : 1'b0;
    // (R24) message type in the low five bits
    tx_f.mtype = tx_type_i;
  end

  // (R25) header word registered for the transmitter
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_valid_ff <= 1'b0;
      tx_hdr_ff <= 16'h0;
    end else begin
      tx_valid_ff <= tx_req_i;
      if (tx_req_i) begin
        tx_hdr_ff <= tx_f;
      end
    end
  end

  // ****************************************
  // Receive header split
  // ****************************************
  wire pdhdr_fields_t rx_f = rx_hdr_i;
  wire rx_sop = (rx_sop_i == SOP_P);
  wire [1:0] rx_sop_idx = (rx_sop_i == SOP_DPRIME) ? SOP_DPRIME : rx_sop_i;
  wire rx_ctrl = !rx_f.ext && (rx_f.ndo == 3'h0);
  wire rx_data = !rx_f.ext && (rx_f.ndo != 3'h0);
  wire rx_gcrc = rx_ctrl && (rx_f.mtype == TYPE_GOODCRC);
  wire rx_psrdy = rx_valid_i && rx_sop && rx_ctrl && (rx_f.mtype == PSRDY_TYPE);
  // (R11) the received power role is never used; our own role picks which capability message to learn from
  wire rx_caps = rx_valid_i && rx_sop && rx_data &&
                 (rx_f.mtype == (prole_ff ? REQUEST_TYPE : SRCCAP_TYPE));
  // (R20) same data role as ours, GoodCRC excepted
  wire rx_role_clash = rx_valid_i && rx_sop && !rx_gcrc && (rx_f.drole == drole_ff);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_valid_ff <= 1'b0;
      rx_fields_ff <= '0;
      rx_kind_ff <= KIND_CTRL;
      rx_ndo_valid_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      rx_valid_ff <= rx_valid_i;
      err_ff <= rx_role_clash;
      if (rx_valid_i) begin
        rx_fields_ff <= rx_f;
        rx_kind_ff <= rx_f.ext ? KIND_EXT : (rx_ctrl ? KIND_CTRL : KIND_DATA);
        // (R03) extended count meaning depends on the chunk flag, not visible here
        rx_ndo_valid_ff <= !rx_f.ext;
      end
    end
  end

  // ****************************************
  // Message ID counters, one per packet type
  // ****************************************
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (sys_rst_i || id_clear) begin
        // (R05) cleared at power-on, Soft Reset and Hard Reset
        msgid_ff[i] <= 3'h0;
        last_rx_id_ff[i] <= 3'h0;
      end else begin
        // (R06) advance on the partner's GoodCRC only
        if (goodcrc_rx_i && (goodcrc_sop_i == i[1:0])) begin
          msgid_ff[i] <= msgid_ff[i] + 3'h1;
        end
        if (rx_valid_i && !rx_gcrc && (rx_sop_idx == i[1:0])) begin
          last_rx_id_ff[i] <= rx_f.id;
        end
      end
    end
  end

  // ****************************************
  // Power role swap tracking
  // ****************************************
  always_comb begin
    nxt_swap = swap_ff;
    nxt_prole = (wr_ctrl0) ? wb_dat_i[CTL_PROLE] : prole_ff;
    case (swap_ff)
      SW_IDLE: begin
        if (swap_arm_p) begin
          nxt_swap = SW_ARMED;
        end
      end
      SW_ARMED: begin
        // (R09) role changes when PS_RDY goes out or comes in
        if (tx_req_i && swap_src_psrdy) begin
          nxt_prole = 1'b0;
          nxt_swap = SW_IDLE;
        end else if (!prole_ff && rx_psrdy) begin
          nxt_prole = 1'b1;
          nxt_swap = SW_GCRC;
        end
      end
      SW_GCRC: begin
        if (tx_req_i && swap_gcrc) begin
          nxt_swap = SW_IDLE;
        end
      end
      default: nxt_swap = SW_IDLE;
    endcase
  end

  // Hardware role change wins over a software write landing in the same cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || hard_rst_p) begin
      swap_ff <= SW_IDLE;
      prole_ff <= 1'b0;
    end else begin
      swap_ff <= nxt_swap;
      prole_ff <= nxt_prole;
    end
  end

  // ****************************************
  // Data role, contract and revision registers
  // ****************************************

  // (R21) default data role from the pull presented
  wire drole_attach = usbcomm_ff ? pullup_ff : prole_ff;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      drole_ff <= 1'b0;
      usbcomm_ff <= 1'b1;
      pullup_ff <= 1'b0;
      contract_ff <= 1'b0;
      local_rev_ff <= LOCAL_REV_RST;
      plug_rev_ff <= PLUG_REV_RST;
    end else begin
      if (attach_p) begin
        // (R22) no USB data: Source gets DFP, Sink gets UFP
        drole_ff <= drole_attach;
      end else if (wr_ctrl0) begin
        drole_ff <= wb_dat_i[CTL_DROLE];
      end
      if (wr_ctrl0) begin
        usbcomm_ff <= wb_dat_i[CTL_USBCOMM];
        pullup_ff <= wb_dat_i[CTL_PULLUP];
      end
      if (detach_p || hard_rst_p) begin
        contract_ff <= 1'b0;
      end else if (wr_ctrl0) begin
        contract_ff <= wb_dat_i[CTL_CONTRACT];
      end
      if (wr_rev0) begin
        // (R14) never below 2.0
        local_rev_ff <= rev_legal(wb_dat_i[1:0]);
        plug_rev_ff <= rev_legal(wb_dat_i[3:2]);
      end
    end
  end

  // (R15) partner revision held until detach
  // A capability message landing with a detach write wins while no contract is held, so a fresh partner is not forgotten.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      partner_rev_ff <= REV_20;
      partner_known_ff <= 1'b0;
    end else if (rx_caps && !contract_ff) begin
      partner_rev_ff <= rev_legal(rx_f.rev);
      partner_known_ff <= 1'b1;
    end else if (detach_p) begin
      partner_rev_ff <= REV_20;
      partner_known_ff <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;
  assign tx_valid_o = tx_valid_ff;
  assign tx_hdr_o = tx_hdr_ff;
  assign rx_valid_o = rx_valid_ff;
  assign rx_fields_o = rx_fields_ff;
  assign rx_kind_o = rx_kind_ff;
  assign rx_ndo_valid_o = rx_ndo_valid_ff;
  assign err_recovery_o = err_ff;

  // ****************************************
  // Checks
  // ****************************************
  chk_ext_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R01)
    tx_req_i |=> tx_hdr_o[15] == $past(tx_ext_i)) else $error("extended flag mismatch");
  chk_ndo_plain: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R02)
    tx_req_i && !tx_ext_i |=> tx_hdr_o[14:12] == $past(tx_ndo_i)) else $error("object count mismatch");
  chk_chunk_full: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R04)
    tx_req_i && tx_ext_i && tx_chunked_i && tx_chunk_bytes_i == 5'h1A |=> tx_hdr_o[14:12] == 3'h7)
    else $error("full chunk count wrong");
  chk_id_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R05)
    id_clear |=> msgid_ff[0] == 3'h0 && msgid_ff[1] == 3'h0 && msgid_ff[2] == 3'h0)
    else $error("message id not cleared");
  chk_id_advance: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R06)
    !id_clear && !(goodcrc_rx_i && goodcrc_sop_i == SOP_P) |=> $stable(msgid_ff[0]))
    else $error("message id moved without goodcrc");
  chk_rev_legal: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R12)
    tx_valid_o |-> tx_hdr_o[7:6] != REV_RSVD && tx_hdr_o[7:6] != REV_10) else $error("illegal revision sent");
  chk_plug_rev: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R16)
    tx_req_i && tx_sop_i != SOP_P && !contract_ff |=> tx_hdr_o[7:6] == REV_20)
    else $error("plug revision before contract");
  chk_gotomin_src: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R08)
    tx_req_i && tx_sop && src_only |=> tx_hdr_o[8]) else $error("source-only message sent as sink");
  chk_drole_sop: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R19)
    tx_req_i && tx_sop_i != SOP_P |=> !tx_hdr_o[5] && !tx_hdr_o[8]) else $error("role bits set off SOP");
  chk_err_recov: assert property (@(posedge clk_i) disable iff (sys_rst_i) // (R20)
    rx_valid_i && rx_sop && !rx_gcrc && rx_hdr_i[5] == drole_ff |=> err_recovery_o)
    else $error("data role clash missed");

endmodule : pdhdr_top
`default_nettype wire

// ==== verification/pd_message_header_fields_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Header block bench
// ****************************************
module pd_message_header_fields_tb import pdhdr_pkg::*;;
  logic clk_i, sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_req_i, tx_ext_i, tx_chunked_i;
  logic tx_from_pe_i, tx_valid_o, goodcrc_rx_i, rx_valid_i, rx_valid_o, rx_ndo_valid_o, err_recovery_o;
  logic slow, mute, pe;
  logic [1:0] tx_sop_i, goodcrc_sop_i, rx_sop_i, rx_kind_o;
  logic [2:0] tx_ndo_i;
  logic [3:0] wb_sel_i;
  logic [4:0] tx_type_i, tx_chunk_bytes_i;
  logic [7:0] wb_adr_i;
  logic [15:0] tx_hdr_o, rx_hdr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  pdhdr_fields_t rx_fields_o;
  logic [2:0] eid [3];
  int fails, checks;

  pdhdr_top dut (.clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .tx_req_i, .tx_sop_i, .tx_type_i, .tx_ndo_i, .tx_ext_i, .tx_chunked_i,
    .tx_chunk_bytes_i, .tx_from_pe_i, .tx_valid_o, .tx_hdr_o, .goodcrc_rx_i, .goodcrc_sop_i, .rx_valid_i,
    .rx_sop_i, .rx_hdr_i, .rx_valid_o, .rx_fields_o, .rx_kind_o, .rx_ndo_valid_o, .err_recovery_o);

  pdhdr_partner partner (.clk_i, .tx_valid_i(tx_valid_o), .hdr_i(tx_hdr_o), .sop_i(tx_sop_i),
    .slow_i(slow), .mute_i(mute), .goodcrc_o(goodcrc_rx_i), .goodcrc_sop_o(goodcrc_sop_i));

  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // One classic cycle; the wait is bounded only by the watchdog.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // Expected transmit header; cable plug and data role bits are zero off SOP.
  function automatic logic [15:0] hx(logic e, logic [2:0] n, logic [1:0] sp, logic pr, logic [1:0] rv,
      logic dr, logic [4:0] ty);
    return {e, n, eid[sp], sp == SOP_P ? pr : 1'b0, rv, sp == SOP_P ? dr : 1'b0, ty};
  endfunction : hx

  // Sends one header request, checks it, then leaves room for the partner's answer.
  task automatic tx(input logic [1:0] sp, input logic [4:0] ty, input logic [2:0] n, input logic e,
      input logic c, input logic [4:0] b, input logic [15:0] exp);
    @(posedge clk_i);
    tx_req_i <= 1'b1;
    tx_sop_i <= sp;
    tx_type_i <= ty;
    tx_ndo_i <= n;
    tx_ext_i <= e;
    tx_chunked_i <= c;
    tx_chunk_bytes_i <= b;
    tx_from_pe_i <= pe;
    @(posedge clk_i);
    tx_req_i <= 1'b0;
    #1;
    chk(tx_valid_o, 1);
    chk(tx_hdr_o, exp);
    repeat (7) @(posedge clk_i);
  endtask : tx

  task automatic rx(input logic [1:0] sp, input logic [15:0] h, input logic er, input logic [1:0] k);
    @(posedge clk_i);
    rx_valid_i <= 1'b1;
    rx_sop_i <= sp;
    rx_hdr_i <= h;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    rx_hdr_i <= ~h;
    #1;
    chk(rx_valid_o, 1);
    chk(rx_fields_o, h);
    chk(err_recovery_o, er);
    chk(rx_kind_o, k);
    chk(rx_ndo_valid_o, !h[15]);
  endtask : rx

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report();
  end

  // Main sequence.
  initial begin
    logic [1:0] sp;
    logic [4:0] ty;
    logic [2:0] n;
    logic pr;
    {sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, tx_req_i, tx_ext_i, tx_chunked_i, tx_from_pe_i} = 8'h80;
    {rx_valid_i, slow, mute, pe, tx_sop_i, rx_sop_i, tx_ndo_i, tx_type_i, tx_chunk_bytes_i} = 0;
    {wb_sel_i, wb_adr_i, rx_hdr_i, wb_dat_i} = 0;
    eid = '{3'h0, 3'h0, 3'h0};
    void'($urandom(32'h13FE3B8F));
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    wb(0, PDHDR_CTRL_OFS, 0, 4'hF);
    chk(rd, 32'h4);
    wb(0, PDHDR_REV_OFS, 0, 4'hF);
    chk(rd, {28'h0, PLUG_REV_RST, LOCAL_REV_RST});
    wb(1, 8'h40, 32'hFFFF, 4'hF);
    wb(0, 8'h40, 0, 4'hF);
    chk(rd, 0);
    pr = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (i == 20) begin
        wb(1, PDHDR_CTRL_OFS, 32'h7, 4'hF);
        pr = 1'b1;
      end
      sp = 2'($urandom_range(2, 0));
      ty = 5'h8 + 5'($urandom_range(7, 0));
      n = 3'($urandom);
      slow <= 1'($urandom);
      mute <= (i % 5 == 4);
      pe = 1'($urandom);
      tx(sp, ty, n, 0, 0, 0, hx(0, n, sp, pr, sp == SOP_P ? LOCAL_REV_RST : REV_20, pr, ty));
      if (i % 5 != 4) eid[sp]++;
    end
    mute <= 1'b0;
    wb(0, PDHDR_MSGID_OFS, 0, 4'hF);
    chk(rd, {21'h0, eid[2], 1'b0, eid[1], 1'b0, eid[0]});
    tx(SOP_P, 5'h9, 3'h5, 1, 1, 5'h1A, hx(1, CHUNK_FULL_NDO, SOP_P, 1, REV_30, 1, 5'h9));
    eid[0]++;
    tx(SOP_P, 5'h9, 3'h5, 1, 1, 5'h05, hx(1, 3'h2, SOP_P, 1, REV_30, 1, 5'h9));
    eid[0]++;
    tx(SOP_P, 5'h9, 3'h5, 1, 0, 5'h07, hx(1, 3'h0, SOP_P, 1, REV_30, 1, 5'h9));
    eid[0]++;
    tx(SOP_P, dut.REQUEST_TYPE, 3'h1, 0, 0, 0, hx(0, 3'h1, SOP_P, 0, REV_30, 1, dut.REQUEST_TYPE));
    eid[0]++;
    wb(1, PDHDR_CTRL_OFS, 32'h4, 4'hF);
    tx(SOP_P, TYPE_GOTOMIN, 0, 0, 0, 0, hx(0, 0, SOP_P, 1, REV_30, 0, TYPE_GOTOMIN));
    eid[0]++;
    tx(SOP_P, dut.PING_TYPE, 0, 0, 0, 0, hx(0, 0, SOP_P, 1, REV_30, 0, dut.PING_TYPE));
    eid[0]++;
    // data role clash and its exceptions
    rx(SOP_P, {4'h0, 3'h2, 1'($urandom), REV_20, 1'b0, 5'h3}, 1, KIND_CTRL);
    rx(SOP_P, {4'h0, 3'h2, 1'($urandom), REV_20, 1'b1, 5'h3}, 0, KIND_CTRL);
    rx(SOP_P, {4'h0, 3'h2, 1'b1, REV_20, 1'b0, TYPE_GOODCRC}, 0, KIND_CTRL);
    // plug replies give its own highest revision on both plug addresses
    rx(SOP_PRIME, {4'h0, 3'h2, 1'b1, REV_30, 1'b0, 5'h3}, 0, KIND_CTRL);
    rx(SOP_DPRIME, {4'h0, 3'h2, 1'b1, REV_30, 1'b0, 5'h3}, 0, KIND_CTRL);
    rx(SOP_P, {4'hF, 3'h1, 1'b0, REV_20, 1'b1, 5'h9}, 0, KIND_EXT);
    // learn, agree and keep revision until detach
    rx(SOP_P, {4'h1, 3'h3, 1'b1, REV_20, 1'b1, dut.SRCCAP_TYPE}, 0, KIND_DATA);
    wb(1, PDHDR_CTRL_OFS, 32'h14, 4'hF);
    wb(0, PDHDR_STAT_OFS, 0, 4'hF);
    chk(rd[6:0], {1'b1, REV_20, REV_20, REV_20});
    tx(SOP_P, 5'hA, 0, 0, 0, 0, hx(0, 0, SOP_P, 0, REV_20, 0, 5'hA));
    eid[0]++;
    wb(1, PDHDR_CTRL_OFS, 32'h200, 4'h2);
    tx(SOP_P, 5'hA, 0, 0, 0, 0, hx(0, 0, SOP_P, 0, REV_30, 0, 5'hA));
    eid[0]++;
    // swap: initial Source marks its ready message Sink
    wb(1, PDHDR_CTRL_OFS, 32'h25, 4'hF);
    pe = 1'b1;
    tx(SOP_P, dut.PSRDY_TYPE, 0, 0, 0, 0, hx(0, 0, SOP_P, 0, REV_30, 0, dut.PSRDY_TYPE));
    eid[0]++;
    wb(0, PDHDR_CTRL_OFS, 0, 4'hF);
    chk(rd[CTL_PROLE], 0);
    // initial Sink: protocol GoodCRC stays Sink, then policy messages say Source
    wb(1, PDHDR_CTRL_OFS, 32'h20, 4'hF);
    rx(SOP_P, {4'h0, 3'h5, 1'b1, REV_30, 1'b1, dut.PSRDY_TYPE}, 0, KIND_CTRL);
    pe = 1'b0;
    tx(SOP_P, TYPE_GOODCRC, 0, 0, 0, 0, {4'h0, 3'h5, 1'b0, REV_30, 1'b0, TYPE_GOODCRC});
    pe = 1'b1;
    tx(SOP_P, 5'hA, 0, 0, 0, 0, hx(0, 0, SOP_P, 1, REV_30, 0, 5'hA));
    // message counters cleared by Soft Reset
    wb(1, PDHDR_CTRL_OFS, 32'h400, 4'h2);
    wb(0, PDHDR_MSGID_OFS, 0, 4'hF);
    chk(rd, 0);
    for (int i = 0; i < 8; i++) begin
      wb(1, PDHDR_CTRL_OFS, {28'h0, i[2:1], 1'b0, i[0]}, 4'h1);
      wb(1, PDHDR_CTRL_OFS, 32'h900, 4'h2);
      wb(0, PDHDR_CTRL_OFS, 0, 4'hF);
      chk(rd[CTL_DROLE], i[1] ? i[2] : i[0]);
    end
    final_report();
  end
endmodule : pd_message_header_fields_tb
`default_nettype wire

// ==== verification/pdhdr_partner.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Far-end port partner
// ****************************************
module pdhdr_partner
  import pdhdr_pkg::*;
(
  // Clock and link side.
  input wire logic clk_i,
  input wire logic tx_valid_i,
  input wire logic [15:0] hdr_i,
  input wire logic [1:0] sop_i,
  // Bench controls: slow answer, or a frame lost on the wire.
  input wire logic slow_i,
  input wire logic mute_i,
  output logic goodcrc_o,
  output logic [1:0] goodcrc_sop_o
);
  // Each frame but a GoodCRC is answered after 1 or 4 cycles; a lost frame gets no answer at all.
  // answer good frames
  initial begin
    logic [1:0] s;
    goodcrc_o = 1'b0;
    goodcrc_sop_o = 2'h3;
    forever begin
      @(posedge clk_i);
      if (tx_valid_i && !mute_i && hdr_i[4:0] != TYPE_GOODCRC) begin
        s = sop_i;
        repeat (slow_i ? 4 : 1) @(posedge clk_i);
        goodcrc_o <= 1'b1;
        goodcrc_sop_o <= s;
        @(posedge clk_i);
        goodcrc_o <= 1'b0;
        goodcrc_sop_o <= ~s; // Released lines must not keep the last packet type.
      end
    end
  end
endmodule : pdhdr_partner
`default_nettype wire
